// ===== src/ivp_ctrl.sv
// Interrupt vectoring, priority and wake-up controller with APB registers.
// Assumes a core on pclk that acknowledges vectors and signals returns.
//
// Contract
// [RULE1] Vector slots and start address lie within ffe0h to ffffh.
// [RULE2] Each slot holds a 16-bit handler address loaded on acceptance.
// [RULE3] All reset causes vector through fffeh at priority 15.
// [RULE4] Reset/NMI pin event sets its flag, served at priority 14.
// [RULE5] Oscillator fault sets its flag and requests as nonmaskable.
// [RULE6] Flash access violation sets its flag, requests as nonmaskable.
// [RULE7] Timer channel 0 alone drives the priority 6 vector.
// [RULE8] Timer channels 1, 2 and overflow share priority 5 vector.
// [RULE9] Eight port one pin flags merge into one request.
// [RULE10] DAC channel 0 requests through ffe4h at priority 2.
// [RULE11] Eight port two pin flags share ffe2h at priority 1.
// [RULE12] Acceptance wakes from any sleep level; return restores it.
// [RULE13] Peripheral flags stay in their peripherals; only observed here.
// [RULE14] Own enable blocks nonmaskable sources; global enable does not.
// [RULE15] Fetch from 0h..01ffh or unused ranges forces a reset.
// [RULE16] Highest pending priority wins; maskable needs global enable.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ivp_ctrl #(
   parameter logic [3:0]  PORT1_SLOT = ivp_pkg::SLOT_PORT1,
   parameter logic [15:0] UNUSED_A_LO = ivp_pkg::UNUSED_A_LO,
   parameter logic [15:0] UNUSED_A_HI = ivp_pkg::UNUSED_A_HI,
   parameter logic [15:0] UNUSED_B_LO = ivp_pkg::UNUSED_B_LO,
   parameter logic [15:0] UNUSED_B_HI = ivp_pkg::UNUSED_B_HI
) (
   // Clock, reset, enable
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        ce,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ivp_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   output wire logic                        pready,
   output wire logic [31:0]                 prdata,
   output wire logic                        pslverr,
   // Pins
   input  wire logic                        rst_nmi_pin,
   input  wire logic                        osc_fault_pin,
   // Reset causes and fault pulses
   input  wire logic                        watchdog_event_flag,
   input  wire logic                        flash_key_violation,
   input  wire logic                        flash_access_violation_flag,
   // Peripheral flags
   input  wire logic                        timer_channel0_flag,
   input  wire logic                        timer_channel1_flag,
   input  wire logic                        timer_channel2_flag,
   input  wire logic                        timer_overflow_flag,
   input  wire logic [7:0]                  port_one_pin_flags,
   input  wire logic [7:0]                  port_two_pin_flags,
   input  wire logic                        dac_channel0_flag,
   input  wire logic                        basic_tick_flag,
   // Core side
   input  wire logic                        gie,
   input  wire logic                        irq_ack,
   input  wire logic                        irq_return,
   input  wire logic                        fetch_valid,
   input  wire logic [15:0]                 fetch_addr,
   output wire logic                        vector_req,
   output wire logic [15:0]                 vector_addr,
   output wire logic [15:0]                 handler_addr,
   output wire logic [3:0]                  vector_prio,
   output wire logic                        sys_reset,
   output wire logic                        cpu_run,
   output wire logic [2:0]                  sleep_level,
   output wire logic                        irq
);
   import ivp_pkg::*;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Port one slot must not collide with a fixed slot
   if (PORT1_SLOT == SLOT_RESET || PORT1_SLOT == SLOT_PIN ||
       PORT1_SLOT == SLOT_FAULT || PORT1_SLOT == SLOT_TMR0 ||
       PORT1_SLOT == SLOT_TMR1  || PORT1_SLOT == SLOT_DAC ||
       PORT1_SLOT == SLOT_PORT2 || PORT1_SLOT == SLOT_TICK) begin : g_chk
      $error("ivp_ctrl: PORT1_SLOT collides with a fixed slot");
   end

   logic [1:0]          pin_s;
   logic                pin_prev_q;
   logic                pin_fall;
   logic [7:0]          status_q;
   logic [7:0]          status_set;
   logic [7:0]          mask_q;
   logic [2:0]          enable_q;
   logic                nmi_mode_q;
   logic                por_q;
   logic                rst_pend_q;
   logic                pc_bad;
   logic [15:0]         vec_q [SLOTS];
   logic [15:0]         pend;
   logic [3:0]          win;
   ivp_state_t          state_q;
   ivp_sleep_t          sleep_q;
   ivp_sleep_t          sleep_d;
   ivp_sleep_t          saved_q;
   logic                accept;
   logic                ret;
   logic                req_q;
   logic [15:0]         vaddr_q;
   logic [15:0]         handler_q;
   logic [3:0]          prio_q;
   logic                cpu_run_q;
   logic                irq_q;
   logic                pready_q;
   logic [31:0]         prdata_q;
   logic                pslverr_q;
   logic [31:0]         rdata;
   logic                mapped;
   logic                is_vec;
   logic                acc;
   logic                wr_en;
   logic [7:0]          w1c;

   // Pin levels cross into pclk; pin idles high, fault idles low
   ivp_sync #(.W(2), .RST_VAL(2'b01)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       ({osc_fault_pin, rst_nmi_pin}),
      .q       (pin_s)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev_q <= 1'b1;
      end else if (ce) begin
         pin_prev_q <= pin_s[0];
      end
   end
   assign pin_fall = pin_prev_q & ~pin_s[0];

   // APB decode; answer comes one cycle into the access phase
   assign acc    = psel & penable;
   assign wr_en  = ce & acc & pready_q & pwrite;
   assign is_vec = (paddr >= OFS_VEC_BASE) && (paddr <= OFS_VEC_END) &&
                   (paddr[1:0] == 2'b00);
   assign mapped = is_vec || paddr == OFS_STATUS || paddr == OFS_MASK ||
                   paddr == OFS_ENABLE || paddr == OFS_CONTROL ||
                   paddr == OFS_STATE;
   assign w1c    = (wr_en && paddr == OFS_STATUS) ? pwdata[7:0] : 8'h00;

   always_comb begin
      rdata = 32'h0000_0000;
      if (is_vec) begin
         rdata = {16'h0000, vec_q[paddr[5:2]]};
      end else begin
         case (paddr)
            OFS_STATUS:  rdata = {24'h000000, status_q};
            OFS_MASK:    rdata = {24'h000000, mask_q};
            OFS_ENABLE:  rdata = {29'h00000000, enable_q};
            OFS_CONTROL: rdata = {25'h0000000, sleep_q, 3'h0, nmi_mode_q};
            OFS_STATE:   rdata = {22'h000000, state_q, prio_q, cpu_run_q,
                                  rst_pend_q, irq_q, req_q};
            default:     rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         pready_q  <= acc & ~pready_q;
         pslverr_q <= acc & ~pready_q & ~mapped;
         prdata_q  <= (acc & ~pready_q & ~pwrite) ? rdata : 32'h0000_0000;
      end
   end

   // Software settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q     <= MASK_RST;
         enable_q   <= ENABLE_RST;
         nmi_mode_q <= 1'b0;
      end else if (wr_en) begin
         if (paddr == OFS_MASK) begin
            mask_q <= pwdata[7:0];
         end
         if (paddr == OFS_ENABLE) begin
            enable_q <= pwdata[ENABLE_W-1:0];
         end
         if (paddr == OFS_CONTROL) begin
            nmi_mode_q <= pwdata[CTL_NMI_MODE];
         end
      end
   end

   // [RULE1] [RULE2] Handler words of the top region
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < SLOTS; i++) begin
            vec_q[i] <= VEC_WORD_RST;
         end
      end else if (wr_en && is_vec) begin
         vec_q[paddr[5:2]] <= pwdata[15:0];
      end
   end

   // [RULE15] Fetch trap ranges
   assign pc_bad = fetch_valid && (fetch_addr <= PERIPH_TOP ||
                   (fetch_addr >= UNUSED_A_LO && fetch_addr <= UNUSED_A_HI) ||
                   (fetch_addr >= UNUSED_B_LO && fetch_addr <= UNUSED_B_HI));

   // [RULE4] [RULE5] [RULE6] System flag sources
   always_comb begin
      status_set          = 8'h00;
      status_set[BIT_NMI] = nmi_mode_q & pin_fall;
      status_set[BIT_OSC] = pin_s[1];
      status_set[BIT_ACV] = flash_access_violation_flag;
      status_set[BIT_POR] = por_q;
      status_set[BIT_EXT] = ~nmi_mode_q & ~pin_s[0];
      status_set[BIT_WDT] = watchdog_event_flag;
      status_set[BIT_KEY] = flash_key_violation;
      status_set[BIT_PCR] = pc_bad;
   end

   // Sticky flags; a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= 8'h00;
         irq_q    <= 1'b0;
      end else if (ce) begin
         status_q <= (status_q & ~w1c) | status_set;
         irq_q    <= |(status_q & mask_q);
      end
   end

   // [RULE3] Every reset cause funnels into one pending reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_q      <= 1'b1;
         rst_pend_q <= 1'b0;
      end else if (ce) begin
         por_q <= 1'b0;
         if (|status_set[BIT_PCR:BIT_POR]) begin
            rst_pend_q <= 1'b1;
         end else if (accept && prio_q == SLOT_RESET) begin
            rst_pend_q <= 1'b0;
         end
      end
   end

   // [RULE13] Peripheral flags are only observed, never stored
   always_comb begin
      pend             = 16'h0000;
      pend[SLOT_RESET] = rst_pend_q;
      // [RULE14] Own enable only
      pend[SLOT_PIN]   = status_q[BIT_NMI] & enable_q[BIT_NMI];
      pend[SLOT_FAULT] = (status_q[BIT_OSC] & enable_q[BIT_OSC]) |
                         (status_q[BIT_ACV] & enable_q[BIT_ACV]);
      // [RULE7] Channel 0 alone
      pend[SLOT_TMR0]  = gie & timer_channel0_flag;
      // [RULE8] Shared timer vector
      pend[SLOT_TMR1]  = gie & (timer_channel1_flag | timer_channel2_flag |
                                timer_overflow_flag);
      // [RULE9] Any port one pin
      pend[PORT1_SLOT] = gie & (|port_one_pin_flags);
      // [RULE10] DAC channel 0
      pend[SLOT_DAC]   = gie & dac_channel0_flag;
      // [RULE11] Any port two pin
      pend[SLOT_PORT2] = gie & (|port_two_pin_flags);
      pend[SLOT_TICK]  = gie & basic_tick_flag;
   end

   // [RULE16] Highest number wins
   assign win    = top_slot(pend);
   assign accept = ce & (state_q == SV_REQ) & irq_ack;
   assign ret    = ce & (state_q == SV_SERVE) & irq_return & ~rst_pend_q;

   // [RULE12] Wake on acceptance, restore on return
   always_comb begin
      sleep_d = sleep_q;
      if (accept) begin
         sleep_d = SLP_ACTIVE;
      end else if (ret) begin
         sleep_d = saved_q;
      end else if (wr_en && paddr == OFS_CONTROL &&
                   pwdata[CTL_SLEEP_LSB+:SLEEP_W] <= SLP_FOUR) begin
         sleep_d = ivp_sleep_t'(pwdata[CTL_SLEEP_LSB+:SLEEP_W]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_q   <= SLP_ACTIVE;
         saved_q   <= SLP_ACTIVE;
         cpu_run_q <= 1'b1;
      end else if (ce) begin
         sleep_q   <= sleep_d;
         cpu_run_q <= sleep_d == SLP_ACTIVE;
         if (accept) begin
            saved_q <= sleep_q;
         end
      end
   end

   // Service sequence; only reset preempts a vector in flight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q   <= SV_IDLE;
         req_q     <= 1'b0;
         prio_q    <= SLOT_TICK;
         vaddr_q   <= VEC_BASE;
         handler_q <= VEC_WORD_RST;
      end else if (ce) begin
         case (state_q)
            SV_IDLE: begin
               if (|pend) begin
                  state_q   <= SV_REQ;
                  req_q     <= 1'b1;
                  prio_q    <= win;
                  vaddr_q   <= slot_addr(win);
                  handler_q <= vec_q[win];
               end
            end
            SV_REQ: begin
               if (irq_ack) begin
                  req_q   <= 1'b0;
                  state_q <= (prio_q == SLOT_RESET) ? SV_IDLE : SV_SERVE;
               end else if (rst_pend_q && prio_q != SLOT_RESET) begin
                  prio_q    <= SLOT_RESET;
                  vaddr_q   <= RESET_VEC;
                  handler_q <= vec_q[SLOT_RESET];
               end
            end
            SV_SERVE: begin
               if (rst_pend_q) begin
                  state_q   <= SV_REQ;
                  req_q     <= 1'b1;
                  prio_q    <= SLOT_RESET;
                  vaddr_q   <= RESET_VEC;
                  handler_q <= vec_q[SLOT_RESET];
               end else if (irq_return) begin
                  state_q <= SV_IDLE;
               end
            end
            default: begin
               state_q <= SV_IDLE;
               req_q   <= 1'b0;
            end
         endcase
      end
   end

   assign pready       = pready_q;
   assign prdata       = prdata_q;
   assign pslverr      = pslverr_q;
   assign vector_req   = req_q;
   assign vector_addr  = vaddr_q;
   assign handler_addr = handler_q;
   assign vector_prio  = prio_q;
   assign sys_reset    = rst_pend_q;
   assign cpu_run      = cpu_run_q;
   assign sleep_level  = sleep_q;
   assign irq          = irq_q;

   a_vector_region: assert property ( // [RULE1]
      req_q |-> vaddr_q >= VEC_BASE && vaddr_q[0] == 1'b0)
      else $error("vector outside top region");
   a_handler_word: assert property ( // [RULE2]
      $rose(req_q) && !$past(wr_en) |-> handler_q == vec_q[prio_q])
      else $error("handler word not the slot word");
   a_reset_first: assert property ( // [RULE3]
      ce && state_q == SV_IDLE && rst_pend_q
      |=> req_q && prio_q == SLOT_RESET && vaddr_q == RESET_VEC)
      else $error("reset not vectored at top slot");
   a_pin_flag: assert property ( // [RULE4]
      ce && nmi_mode_q && pin_fall |=> status_q[BIT_NMI])
      else $error("pin event flag not set");
   a_osc_flag: assert property ( // [RULE5]
      ce && pin_s[1] |=> status_q[BIT_OSC])
      else $error("oscillator fault flag not set");
   a_acv_flag: assert property ( // [RULE6]
      ce && flash_access_violation_flag |=> status_q[BIT_ACV])
      else $error("access violation flag not set");
   a_timer_zero: assert property ( // [RULE7]
      ce && state_q == SV_IDLE && gie && timer_channel0_flag &&
      pend[15:7] == 9'h000 |=> req_q && prio_q == SLOT_TMR0)
      else $error("timer channel 0 not at its slot");
   a_wake_restore: assert property ( // [RULE12]
      accept |=> cpu_run_q && sleep_q == SLP_ACTIVE &&
      saved_q == $past(sleep_q))
      else $error("acceptance did not wake the core");
   a_nmi_ungated: assert property ( // [RULE14]
      ce && state_q == SV_IDLE && !rst_pend_q && !gie &&
      status_q[BIT_NMI] && enable_q[BIT_NMI] |=> prio_q == SLOT_PIN)
      else $error("pin request blocked by global enable");
   a_fetch_trap: assert property ( // [RULE15]
      ce && fetch_valid && fetch_addr <= PERIPH_TOP
      |=> rst_pend_q && status_q[BIT_PCR])
      else $error("fetch trap did not reset");
   a_gie_blocks: assert property ( // [RULE16]
      ce && state_q == SV_IDLE && !gie && !rst_pend_q &&
      (status_q[2:0] & enable_q) == 3'h0 |=> !req_q)
      else $error("maskable request without global enable");
endmodule : ivp_ctrl

// ===== src/ivp_pkg.sv
// Constants, types and helpers of the interrupt vector and priority block.
// Assumes a 16-bit core address space with vectors in the top 32 bytes.
package ivp_pkg;

   // APB register map (byte addresses)
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  OFS_STATUS    = 8'h00;
   localparam logic [7:0]  OFS_MASK      = 8'h04;
   localparam logic [7:0]  OFS_ENABLE    = 8'h08;
   localparam logic [7:0]  OFS_CONTROL   = 8'h0c;
   localparam logic [7:0]  OFS_STATE     = 8'h10;
   localparam logic [7:0]  OFS_VEC_BASE  = 8'h40;
   localparam logic [7:0]  OFS_VEC_END   = 8'h7c;

   // Status bits, also the mask layout
   localparam int          STATUS_W      = 8;
   localparam int          BIT_NMI       = 0;
   localparam int          BIT_OSC       = 1;
   localparam int          BIT_ACV       = 2;
   localparam int          BIT_POR       = 3;
   localparam int          BIT_EXT       = 4;
   localparam int          BIT_WDT       = 5;
   localparam int          BIT_KEY       = 6;
   localparam int          BIT_PCR       = 7;
   localparam int          ENABLE_W      = 3;

   // Control fields
   localparam int          CTL_NMI_MODE  = 0;
   localparam int          CTL_SLEEP_LSB = 4;
   localparam int          SLEEP_W       = 3;

   // Reset values
   localparam logic [7:0]  MASK_RST      = 8'h00;
   localparam logic [2:0]  ENABLE_RST    = 3'h0;
   localparam logic [15:0] VEC_WORD_RST  = 16'h0000;

   // Vector region and slots (slot number is the priority)
   localparam logic [15:0] VEC_BASE      = 16'hffe0;
   localparam logic [15:0] VEC_TOP       = 16'hffff;
   localparam logic [15:0] RESET_VEC     = 16'hfffe;
   localparam int          SLOTS         = 16;
   localparam logic [3:0]  SLOT_RESET    = 4'hf;
   localparam logic [3:0]  SLOT_PIN      = 4'he;
   localparam logic [3:0]  SLOT_FAULT    = 4'hd;
   localparam logic [3:0]  SLOT_TMR0     = 4'h6;
   localparam logic [3:0]  SLOT_TMR1     = 4'h5;
   localparam logic [3:0]  SLOT_PORT1    = 4'h4;
   localparam logic [3:0]  SLOT_DAC      = 4'h2;
   localparam logic [3:0]  SLOT_PORT2    = 4'h1;
   localparam logic [3:0]  SLOT_TICK     = 4'h0;

   // Address ranges that trap a fetch
   localparam logic [15:0] PERIPH_TOP    = 16'h01ff;
   localparam logic [15:0] UNUSED_A_LO   = 16'h0300;
   localparam logic [15:0] UNUSED_A_HI   = 16'h0bff;
   localparam logic [15:0] UNUSED_B_LO   = 16'h1100;
   localparam logic [15:0] UNUSED_B_HI   = 16'h7fff;

   typedef enum logic [2:0] {
      SLP_ACTIVE = 3'b000,
      SLP_ZERO   = 3'b001,
      SLP_ONE    = 3'b010,
      SLP_TWO    = 3'b011,
      SLP_THREE  = 3'b100,
      SLP_FOUR   = 3'b101
   } ivp_sleep_t;

   typedef enum logic [1:0] {
      SV_IDLE  = 2'b00,
      SV_REQ   = 2'b01,
      SV_SERVE = 2'b10
   } ivp_state_t;

   // Word address of a vector slot
   function automatic logic [15:0] slot_addr(input logic [3:0] slot);
      slot_addr = VEC_BASE + {11'h000, slot, 1'b0};
   endfunction : slot_addr

   // Highest set request wins
   function automatic logic [3:0] top_slot(input logic [15:0] pend);
      top_slot = 4'h0;
      for (int i = 0; i < SLOTS; i++) begin
         if (pend[i]) begin
            top_slot = 4'(i);
         end
      end
   endfunction : top_slot

endpackage : ivp_pkg

// ===== src/ivp_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the reset value matches the idle level of each pin.
`timescale 1ns/1ps
module ivp_sync #(
   parameter int         W       = 2,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   // Levels
   input  wire logic [W-1:0] d,
   output wire logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // A zero-wide bundle has nothing to carry
   if (W < 1) begin : g_chk
      $error("ivp_sync: W must be at least 1");
   end

   // First stage is read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else if (ce) begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule : ivp_sync

// ===== tb/ivp_core_model.sv
// Core model: takes each vector after a short wait, returns later except from a reset vector.
// Assumes irq_ack is sampled only while vector_req is high.
`timescale 1ns/1ps
module ivp_core_model (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Vector side
   input  wire logic       vector_req,
   input  wire logic [3:0] vector_prio,
   output logic            irq_ack,
   output logic            irq_return
);
   logic [3:0] wait_q;
   logic [4:0] ret_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ack <= 1'b0;
         wait_q  <= 4'h0;
      end else if (irq_ack) begin
         irq_ack <= 1'b0;
         wait_q  <= 4'h0;
      end else if (vector_req) begin
         // Slow answer, so a late reset may still replace the vector
         wait_q  <= wait_q + 4'h1;
         irq_ack <= (wait_q == 4'h2);
      end
   end
   // Handler of fixed length; a reset vector never returns
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ret_q      <= 5'h00;
         irq_return <= 1'b0;
      end else begin
         irq_return <= (ret_q == 5'h01);
         if (irq_ack && vector_prio != 4'hf) begin
            ret_q <= 5'h0c;
         end else if (ret_q != 5'h00) begin
            ret_q <= ret_q - 5'h01;
         end
      end
   end
endmodule : ivp_core_model

// ===== tb/test_interrupt_vector_priority.sv
// Bench for the vector controller: APB master, flags and a core model.
// Assumes a 10 MHz pclk and the package register map.
`timescale 1ns/1ps
module test_interrupt_vector_priority;
   import ivp_pkg::*;
   logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0, p1 = 0, p2 = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, err, nmi_pin = 1, osc = 0, gie = 0, fv = 0;
   logic [8:0] fl = 0;
   logic [15:0] fa = 0, vector_addr, handler_addr;
   logic [3:0] vector_prio;
   logic [2:0] sleep_level;
   logic irq_ack, irq_return, vector_req, sys_reset, cpu_run, irq;
   int num_errors = 0, n_compared = 0, cyc = 0;
   always #50 pclk = ~pclk;
   ivp_ctrl u_ivp_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .rst_nmi_pin(nmi_pin), .osc_fault_pin(osc),
      .watchdog_event_flag(fl[7]), .flash_key_violation(fl[8]),
      .flash_access_violation_flag(fl[6]), .timer_channel0_flag(fl[0]),
      .timer_channel1_flag(fl[1]), .timer_channel2_flag(fl[2]),
      .timer_overflow_flag(fl[3]), .port_one_pin_flags(p1),
      .port_two_pin_flags(p2), .dac_channel0_flag(fl[4]),
      .basic_tick_flag(fl[5]), .gie(gie), .irq_ack(irq_ack),
      .irq_return(irq_return), .fetch_valid(fv), .fetch_addr(fa),
      .vector_req(vector_req), .vector_addr(vector_addr),
      .handler_addr(handler_addr), .vector_prio(vector_prio),
      .sys_reset(sys_reset), .cpu_run(cpu_run),
      .sleep_level(sleep_level), .irq(irq));
   ivp_core_model u_ivp_core_model (.pclk(pclk), .presetn(presetn),
      .vector_req(vector_req), .vector_prio(vector_prio),
      .irq_ack(irq_ack), .irq_return(irq_return));
   task automatic wrap_up;
      if (num_errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string n, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   // Wait for a vector, judge it, then play the handler clearing flags
   task automatic wv(input logic [3:0] p);
      int i;
      i = 0;
      while (vector_req !== 1'b1 && i < 30) begin
         @(posedge pclk);
         i++;
      end
      fl <= 0;
      p1 <= 0;
      p2 <= 0;
      nmi_pin <= 1;
      osc <= 0;
      fv <= 0;
      chk("vector_prio", vector_prio, p);
      chk("vector_addr", vector_addr, 16'hffe0 + {p, 1'b0});
      chk("sys_reset", sys_reset, p == 4'hf);
      if (p != 4'hf) chk("handler", handler_addr, 16'hc000 + p);
      while (vector_req === 1'b1) @(posedge pclk);
      @(posedge pclk);
      chk("cpu_run", cpu_run, 1'b1);
      apb(1, OFS_STATUS, 32'hff);
      repeat (14) @(posedge pclk);
   endtask : wv
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      wv(4'hf);
      apb(0, 8'h20, 0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      for (int s = 0; s < 16; s++) begin
         apb(1, OFS_VEC_BASE + 8'(4 * s), 32'hc000 + s);
      end
      apb(0, OFS_VEC_BASE + 8'h18, 0);
      chk("vec_word", rd, 32'hc006);
      apb(1, OFS_CONTROL, 32'h31);
      chk("sleep", {cpu_run, sleep_level}, 4'h3);
      fl[0] <= 1;
      repeat (6) @(posedge pclk);
      chk("gie_block", vector_req, 1'b0);
      gie <= 1;
      fl[4] <= 1;
      wv(4'h6);
      chk("restore", sleep_level, 3'h3);
      for (int k = 1; k < 6; k++) begin
         fl[k] <= 1;
         wv(k < 4 ? 4'h5 : (k == 4 ? 4'h2 : 4'h0));
      end
      for (int k = 0; k < 8; k++) begin
         p1 <= 8'h01 << k;
         wv(SLOT_PORT1);
         p2 <= 8'h01 << k;
         wv(4'h1);
      end
      // Clock enable low holds a pending request back
      ce <= 0;
      fl[5] <= 1;
      repeat (4) @(posedge pclk);
      chk("ce_hold", vector_req, 1'b0);
      ce <= 1;
      wv(4'h0);
      gie <= 0;
      apb(1, OFS_MASK, 1);
      nmi_pin <= 0;
      repeat (8) @(posedge pclk);
      chk("nmi_no_en", vector_req, 1'b0);
      chk("irq", irq, 1'b1);
      nmi_pin <= 1;
      apb(1, OFS_STATUS, 1);
      repeat (2) @(posedge pclk);
      chk("irq_clr", irq, 1'b0);
      apb(1, OFS_ENABLE, 7);
      nmi_pin <= 0;
      wv(4'he);
      osc <= 1;
      wv(4'hd);
      fl[6] <= 1;
      wv(4'hd);
      fv <= 1;
      fa <= 16'hc000;
      repeat (6) @(posedge pclk);
      chk("fetch_ok", sys_reset, 1'b0);
      foreach (fl[k]) if (k > 6) begin
         fl[k] <= 1;
         wv(4'hf);
      end
      for (int k = 0; k < 3; k++) begin
         fv <= 1;
         fa <= k == 0 ? 16'h0100 : (k == 1 ? 16'h0400 : 16'h1200);
         wv(4'hf);
      end
      // Pin in reset mode: a low level is a reset cause
      apb(1, OFS_CONTROL, 32'h0);
      nmi_pin <= 0;
      wv(4'hf);
      wrap_up();
   end
endmodule : test_interrupt_vector_priority
